// ### rtl/dofs_defs.svh
// Offsets, codes and reset values of the output function select block
`ifndef DOFS_DEFS_SVH
`define DOFS_DEFS_SVH
`define DOFS_OFS_OUTPUT1_FUNCTION_CODE 16'h0714
`define DOFS_CODE_FREE 16'h0001
`define DOFS_CODE_NO_FAULT 16'h0002
`define DOFS_CODE_ACTIVE 16'h0003
`define DOFS_CODE_REL_MOVE 16'h0004
`define DOFS_CODE_POS_WIN 16'h0005
`define DOFS_CODE_VEL_WIN 16'h0006
`define DOFS_CODE_VEL_BELOW 16'h0007
`define DOFS_CODE_CUR_BELOW 16'h0008
`define DOFS_CODE_HALT_ACK 16'h0009
`define DOFS_CODE_STANDSTILL 16'h000D
`define DOFS_CODE_SEL_ERROR 16'h000E
`define DOFS_CODE_REF_OK 16'h000F
`define DOFS_CODE_SEL_WARN 16'h0010
`define DOFS_CODE_POSREG1 16'h0012
`define DOFS_CODE_POSREG4 16'h0015
`define DOFS_CODE_MOVE_POS 16'h0016
`define DOFS_CODE_MOVE_NEG 16'h0017
`define DOFS_RESET_CODE 16'h0001
`endif

// ### rtl/dofs_pkg.sv
// Types shared by the output function select block
package dofs_pkg;
    typedef struct packed {
        logic ready_to_switch_on;
        logic switched_on;
        logic operation_enabled;
        logic relative_move_after_capture;
        logic pos_dev_in_window;
        logic vel_dev_in_window;
        logic vel_below_threshold;
        logic cur_below_threshold;
        logic halt_ack;
        logic standstill;
        logic selected_error;
        logic ref_ok;
        logic selected_warning;
        logic [3:0] posreg_channel;
        logic moves_positive;
        logic moves_negative;
    } dofs_status_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dofs_req_s;

    typedef struct packed {
        logic [15:0] stored;
        logic [15:0] active;
        logic dout;
        logic [15:0] rdata;
        logic ack;
        logic refused;
        logic nv_wr;
    } dofs_state_s;
endpackage : dofs_pkg

// ### rtl/dofs_top.sv
// Function select logic for digital output one
`timescale 1ns/1ps
`include "dofs_defs.svh"
// ==========================================================
module dofs_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic power_stage_en,
    input wire logic [15:0] nv_code,
    input wire logic free_level,
    input wire dofs_pkg::dofs_status_s status,
    input wire dofs_pkg::dofs_req_s req,
    output logic digital_output_one_r,
    output logic [15:0] par_rdata_r,
    output logic par_ack_r,
    output logic par_refused_r,
    output logic nv_wr_r,
    output logic [15:0] nv_wdata_r
);
    // ======================================================
    // Code validity and selection
    function automatic logic code_valid(input logic [15:0] c);
        logic ok;
        ok = 1'b0;
        if (c >= `DOFS_CODE_FREE && c <= `DOFS_CODE_HALT_ACK) begin
            ok = 1'b1;
        end else if (c >= `DOFS_CODE_STANDSTILL && c <= `DOFS_CODE_SEL_WARN) begin
            ok = 1'b1;
        end else if (c >= `DOFS_CODE_POSREG1 && c <= `DOFS_CODE_MOVE_NEG) begin
            ok = 1'b1;
        end
        return ok;
    endfunction : code_valid

    dofs_pkg::dofs_state_s st_r;
    dofs_pkg::dofs_state_s st_nxt;
    logic sel_level;
    logic [1:0] ch_idx;
    logic [15:0] ch_ofs;
    logic addr_hit;
    logic wr_ok;

    assign addr_hit = (req.addr == `DOFS_OFS_OUTPUT1_FUNCTION_CODE);
    assign ch_ofs = st_r.active - `DOFS_CODE_POSREG1;
    assign ch_idx = ch_ofs[1:0];
    // Refusal covers both the power stage interlock and unlisted codes
    assign wr_ok = !power_stage_en && code_valid(req.wdata);

    always_comb begin
        sel_level = 1'b0;
        case (st_r.active)
            `DOFS_CODE_FREE: sel_level = free_level;
            `DOFS_CODE_NO_FAULT: sel_level = status.ready_to_switch_on
                || status.switched_on || status.operation_enabled;
            `DOFS_CODE_ACTIVE: sel_level = status.operation_enabled;
            `DOFS_CODE_REL_MOVE: sel_level = status.relative_move_after_capture;
            `DOFS_CODE_POS_WIN: sel_level = status.pos_dev_in_window;
            `DOFS_CODE_VEL_WIN: sel_level = status.vel_dev_in_window;
            `DOFS_CODE_VEL_BELOW: sel_level = status.vel_below_threshold;
            `DOFS_CODE_CUR_BELOW: sel_level = status.cur_below_threshold;
            `DOFS_CODE_HALT_ACK: sel_level = status.halt_ack;
            `DOFS_CODE_STANDSTILL: sel_level = status.standstill;
            `DOFS_CODE_SEL_ERROR: sel_level = status.selected_error;
            `DOFS_CODE_REF_OK: sel_level = status.ref_ok;
            `DOFS_CODE_SEL_WARN: sel_level = status.selected_warning;
            `DOFS_CODE_MOVE_POS: sel_level = status.moves_positive;
            `DOFS_CODE_MOVE_NEG: sel_level = status.moves_negative;
            default: begin
                // Ascending channel order from the first channel code
                if (st_r.active >= `DOFS_CODE_POSREG1
                    && st_r.active <= `DOFS_CODE_POSREG4) begin
                    sel_level = status.posreg_channel[ch_idx];
                end
            end
        endcase
    end

    // ======================================================
    // State update
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.refused = 1'b0;
        st_nxt.nv_wr = 1'b0;
        st_nxt.dout = sel_level;
        if (req.wr && addr_hit) begin
            if (wr_ok) begin
                // Only the stored copy moves; active waits for power-on
                st_nxt.stored = req.wdata;
                st_nxt.nv_wr = 1'b1;
                st_nxt.ack = 1'b1;
            end else begin
                st_nxt.refused = 1'b1;
            end
        end else if (req.rd && addr_hit) begin
            st_nxt.rdata = st_r.stored;
            st_nxt.ack = 1'b1;
        end else if (req.wr || req.rd) begin
            st_nxt.refused = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // Power-on: load the persistent value, fall back if corrupt
            st_r.stored <= code_valid(nv_code) ? nv_code : `DOFS_RESET_CODE;
            st_r.active <= code_valid(nv_code) ? nv_code : `DOFS_RESET_CODE;
            st_r.dout <= 1'b0;
            st_r.rdata <= 16'h0000;
            st_r.ack <= 1'b0;
            st_r.refused <= 1'b0;
            st_r.nv_wr <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign digital_output_one_r = st_r.dout;
    assign par_rdata_r = st_r.rdata;
    assign par_ack_r = st_r.ack;
    assign par_refused_r = st_r.refused;
    assign nv_wr_r = st_r.nv_wr;
    assign nv_wdata_r = st_r.stored;

    // ======================================================
    // Assertions
    sequence s_write_hit;
        req.wr && addr_hit;
    endsequence

    sequence s_enabled_write;
        s_write_hit ##0 power_stage_en;
    endsequence

    property p_no_fault;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_NO_FAULT |=> digital_output_one_r ==
            $past(status.ready_to_switch_on || status.switched_on
            || status.operation_enabled);
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("code 2 output wrong");

    property p_active;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_ACTIVE |=>
            digital_output_one_r == $past(status.operation_enabled);
    endproperty
    a_active: assert property (p_active) else $error("code 3 output wrong");

    property p_rel_move;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_REL_MOVE |=>
            digital_output_one_r == $past(status.relative_move_after_capture);
    endproperty
    a_rel_move: assert property (p_rel_move) else $error("code 4 output wrong");

    property p_pos_win;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_POS_WIN |=>
            digital_output_one_r == $past(status.pos_dev_in_window);
    endproperty
    a_pos_win: assert property (p_pos_win) else $error("code 5 output wrong");

    property p_cur_below;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_CUR_BELOW |=>
            digital_output_one_r == $past(status.cur_below_threshold);
    endproperty
    a_cur_below: assert property (p_cur_below) else $error("code 8 output wrong");

    property p_standstill;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_STANDSTILL |=>
            digital_output_one_r == $past(status.standstill);
    endproperty
    a_standstill: assert property (p_standstill) else $error("code 13 wrong");

    property p_sel_error;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_SEL_ERROR |=>
            digital_output_one_r == $past(status.selected_error);
    endproperty
    a_sel_error: assert property (p_sel_error) else $error("code 14 wrong");

    property p_ref_ok;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_REF_OK |=>
            digital_output_one_r == $past(status.ref_ok);
    endproperty
    a_ref_ok: assert property (p_ref_ok) else $error("code 15 wrong");

    property p_sel_warn;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_SEL_WARN |=>
            digital_output_one_r == $past(status.selected_warning);
    endproperty
    a_sel_warn: assert property (p_sel_warn) else $error("code 16 wrong");

    property p_posreg3;
        @(posedge clk) disable iff (srst)
        st_r.active == 16'h0014 |=>
            digital_output_one_r == $past(status.posreg_channel[2]);
    endproperty
    a_posreg3: assert property (p_posreg3) else $error("code 20 wrong");

    property p_move_neg;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_MOVE_NEG |=>
            digital_output_one_r == $past(status.moves_negative);
    endproperty
    a_move_neg: assert property (p_move_neg) else $error("code 23 wrong");

    property p_vel_win;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_VEL_WIN |=>
            digital_output_one_r == $past(status.vel_dev_in_window);
    endproperty
    a_vel_win: assert property (p_vel_win) else $error("code 6 output wrong");

    property p_vel_below;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_VEL_BELOW |=>
            digital_output_one_r == $past(status.vel_below_threshold);
    endproperty
    a_vel_below: assert property (p_vel_below) else $error("code 7 output wrong");

    property p_halt_ack;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_HALT_ACK |=>
            digital_output_one_r == $past(status.halt_ack);
    endproperty
    a_halt_ack: assert property (p_halt_ack) else $error("code 9 output wrong");

    property p_posreg1;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_POSREG1 |=>
            digital_output_one_r == $past(status.posreg_channel[0]);
    endproperty
    a_posreg1: assert property (p_posreg1) else $error("code 18 wrong");

    property p_posreg2;
        @(posedge clk) disable iff (srst)
        st_r.active == 16'h0013 |=>
            digital_output_one_r == $past(status.posreg_channel[1]);
    endproperty
    a_posreg2: assert property (p_posreg2) else $error("code 19 wrong");

    property p_posreg4;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_POSREG4 |=>
            digital_output_one_r == $past(status.posreg_channel[3]);
    endproperty
    a_posreg4: assert property (p_posreg4) else $error("code 21 wrong");

    property p_move_pos;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_MOVE_POS |=>
            digital_output_one_r == $past(status.moves_positive);
    endproperty
    a_move_pos: assert property (p_move_pos) else $error("code 22 wrong");

    // Code 0x16 written with the power stage off must be stored and persisted
    property p_write_taken;
        @(posedge clk) disable iff (srst)
        s_write_hit ##0 (!power_stage_en && req.wdata == `DOFS_CODE_MOVE_POS)
            |=> par_ack_r && nv_wr_r && nv_wdata_r == `DOFS_CODE_MOVE_POS;
    endproperty
    a_write_taken: assert property (p_write_taken) else $error("write lost");

    property p_refuse_enabled;
        @(posedge clk) disable iff (srst)
        s_enabled_write |=> par_refused_r && !par_ack_r
            && !nv_wr_r && $stable(nv_wdata_r);
    endproperty
    a_refuse_enabled: assert property (p_refuse_enabled) else $error("write taken");

    property p_active_held;
        @(posedge clk) disable iff (srst)
        !srst |=> $stable(st_r.active);
    endproperty
    a_active_held: assert property (p_active_held) else $error("active changed");

    property p_free;
        @(posedge clk) disable iff (srst)
        st_r.active == `DOFS_CODE_FREE |=> digital_output_one_r == $past(free_level);
    endproperty
    a_free: assert property (p_free) else $error("code 1 output wrong");

    property p_unlisted;
        @(posedge clk) disable iff (srst)
        s_write_hit ##0 (req.wdata == 16'h000A || req.wdata == 16'h0011)
            |=> par_refused_r && !nv_wr_r;
    endproperty
    a_unlisted: assert property (p_unlisted) else $error("bad code stored");
endmodule : dofs_top

// ### tb/dofs_load.sv
// Model of the equipment wired to digital output one
`timescale 1ns/1ps
// ==========================================
// Input stage of the far side
module dofs_load (
    input wire logic clk,
    input wire logic pin,
    output logic level_r
);
    // Registered input, as a real receiver samples the pin; here on the same clk as the block
    always_ff @(posedge clk) begin
        level_r <= pin;
    end
endmodule : dofs_load

// ### tb/digital_output_function_select_tb_top.sv
// Self-checking bench of the output function select block
`timescale 1ns/1ps
`include "dofs_defs.svh"
module digital_output_function_select_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic power_stage_en = 1'b0;
    logic [15:0] nv_code = 16'h0001;
    logic free_level = 1'b0;
    dofs_pkg::dofs_status_s status = '0;
    dofs_pkg::dofs_req_s req = '0;
    logic dout, ack, refused, nv_wr, seen_level;
    logic [15:0] rdata, nv_wdata, stored_exp, active_code, lfsr = 16'h000F;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [15:0] ADDR = `DOFS_OFS_OUTPUT1_FUNCTION_CODE;
    logic [15:0] codes[$] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 13, 14, 15, 16,
                              18, 19, 20, 21, 22, 23, 11};
    logic [15:0] bad[$] = '{0, 10, 11, 12, 17, 24};

    always #2.5 clk = ~clk;

    dofs_top u_dut (.clk(clk), .srst(srst), .power_stage_en(power_stage_en),
        .nv_code(nv_code), .free_level(free_level), .status(status), .req(req),
        .digital_output_one_r(dout), .par_rdata_r(rdata), .par_ack_r(ack),
        .par_refused_r(refused), .nv_wr_r(nv_wr), .nv_wdata_r(nv_wdata));
    dofs_load u_load (.clk(clk), .pin(dout), .level_r(seen_level));

    // ==========================================
    // Reference model and helpers
    function automatic logic exp_out(input logic [15:0] c, input dofs_pkg::dofs_status_s s,
                                     input logic fl);
        case (c)
            16'h0002: return s.ready_to_switch_on | s.switched_on | s.operation_enabled;
            16'h0003: return s.operation_enabled;
            16'h0004: return s.relative_move_after_capture;
            16'h0005: return s.pos_dev_in_window;
            16'h0006: return s.vel_dev_in_window;
            16'h0007: return s.vel_below_threshold;
            16'h0008: return s.cur_below_threshold;
            16'h0009: return s.halt_ack;
            16'h000D: return s.standstill;
            16'h000E: return s.selected_error;
            16'h000F: return s.ref_ok;
            16'h0010: return s.selected_warning;
            16'h0012, 16'h0013, 16'h0014, 16'h0015:
                return s.posreg_channel[c[1:0] - 2'h2];
            16'h0016: return s.moves_positive;
            16'h0017: return s.moves_negative;
            default: return fl;
        endcase
    endfunction : exp_out

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // Power-on: the stored code is loaded while reset is held
    task automatic power_on(input logic [15:0] code);
        srst = 1'b1;
        nv_code = code;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        stored_exp = (code inside {[1:9], [13:16], [18:23]}) ? code : 16'h0001;
        active_code = stored_exp;
    endtask : power_on

    // Entered at a falling edge; the caller releases req after the last access
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                          input logic ok);
        req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(negedge clk);
        check({15'h0, ack}, {15'h0, ok});
        check({15'h0, refused}, {15'h0, !ok});
        if (wr) check({15'h0, nv_wr}, {15'h0, ok});
        if (ok && wr) begin
            stored_exp = wdata;
            check(nv_wdata, wdata);
        end else if (ok) begin
            check(rdata, stored_exp);
        end else if (wr) begin
            check(nv_wdata, stored_exp);
        end
    endtask : access

    // Random status held long enough for either output latency to settle
    task automatic sample(input int n);
        logic [15:0] a;
        logic e;
        repeat (n) begin
            lfsr = lfsr_next(lfsr);
            a = lfsr;
            lfsr = lfsr_next(lfsr);
            status = dofs_pkg::dofs_status_s'({a, lfsr[2:0]});
            free_level = lfsr[5];
            repeat (3) @(negedge clk);
            e = exp_out(active_code, status, free_level);
            check({15'h0, dout}, {15'h0, e});
            check({15'h0, seen_level}, {15'h0, e});
        end
    endtask : sample

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        @(negedge clk);
        foreach (codes[i]) begin
            power_on(codes[i]);
            access(1'b0, ADDR, 16'h0000, 1'b1);
            req = '0;
            sample(8);
        end
        power_on(16'h0003);
        power_stage_en = 1'b1;
        access(1'b1, ADDR, 16'h0016, 1'b0);
        access(1'b0, ADDR, 16'h0000, 1'b1);
        power_stage_en = 1'b0;
        foreach (bad[i]) access(1'b1, ADDR, bad[i], 1'b0);
        access(1'b1, ADDR + 16'h0002, 16'h0016, 1'b0);
        access(1'b0, ADDR + 16'h0002, 16'h0000, 1'b0);
        access(1'b1, ADDR, 16'h0016, 1'b1);
        access(1'b0, ADDR, 16'h0000, 1'b1);
        req = '0;
        sample(6);
        power_on(nv_wdata);
        sample(6);
        conclude();
    end
endmodule : digital_output_function_select_tb_top
